// [rtl/pec_defines.vh]
`ifndef PEC_DEFINES_VH
`define PEC_DEFINES_VH

`define PEC_PAGE_BYTES      10'd512
`define PEC_HDR_BYTE0       8'h01
`define PEC_SIZE_LSB        12
`define PEC_SIZE_MSB        14
`define PEC_SIZE_16         3'h1
`define PEC_SIZE_32         3'h2
`define PEC_SIZE_48         3'h3
`define PEC_SIZE_64         3'h4
`define PEC_EV_END          12'h000
`define PEC_EV_ICRC_CMD     12'h001
`define PEC_EV_PHY_DROP     12'h009
`define PEC_EV_SIG_SENT     12'h00a
`define PEC_EV_RX_CRC       12'h00b
`define PEC_EV_RX_OTHER     12'h00d
`define PEC_FIRST_ENTRY     10'd4
`define PEC_END_BYTE        10'd24
`define PEC_PAD_FIRST       10'd26
`define PEC_CSUM_BYTE       10'd511
`define PEC_NUM_CNT         5

`endif

// [rtl/pec_event_log.v]
// Functional notes
// - Each entry: 16-bit identifier then value
// - Identifier bits 14:12 hold size code
// - Values fill whole 16-bit words
// - List ends with zero identifier, no value
// - Count commands failed by interface CRC
// - Count own link ready-to-not-ready drops
// - Count signature FISes sent after COMRESET
// - Count received FISes with CRC error
// - Count received FISes with other errors
// - Transmit events outbound, receive events inbound
// - 4-byte header, ordered entries, zero padding
// - Byte 511 makes page sum zero
// - Clear at power-up; no other reset clears
// - Read with clear flag resets after return
// - BIST Activate FIS resets all counters
`timescale 1ns/1ps
`include "pec_defines.vh"

module pec_event_log #(
    parameter CNT_WIDTH = 16
) (
    // Clock and reset
    input  wire       sys_clk_in,
    input  wire       sys_rst_in,
    // Event strobes, one cycle each
    input  wire       icrc_cmd_fail_in,
    input  wire       phy_rdy_drop_in,
    input  wire       sig_fis_sent_in,
    input  wire       rx_fis_crc_err_in,
    input  wire       rx_fis_other_err_in,
    input  wire       bist_activate_in,
    // Page read request
    input  wire       read_start_in,
    input  wire       read_clear_in,
    output wire       read_busy_out,
    // Byte stream out
    output reg  [7:0] page_data_out,
    output reg        page_valid_out,
    output reg        page_last_out,
    input  wire       page_ready_in
);
    localparam ST_IDLE = 2'd0;
    localparam ST_SEND = 2'd1;
    localparam ST_DONE = 2'd2;

    // Width to size code; unlisted widths fall back to the 16-bit code
    function [2:0] size_code;
        input integer width;
        begin
            case (width)
                64:      size_code = `PEC_SIZE_64;
                48:      size_code = `PEC_SIZE_48;
                32:      size_code = `PEC_SIZE_32;
                default: size_code = `PEC_SIZE_16;
            endcase
        end
    endfunction

    localparam [2:0]   SIZE_CODE     = size_code(CNT_WIDTH);
    localparam integer ENTRY_BYTES_I = 2 + CNT_WIDTH / 8;
    localparam [9:0]   ENTRY_BYTES   = ENTRY_BYTES_I[9:0];
    localparam integer LIST_BYTES_I  = ENTRY_BYTES_I * `PEC_NUM_CNT;
    localparam [9:0]   LIST_BYTES    = LIST_BYTES_I[9:0];

    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg  [9:0]  idx_reg;
    reg  [7:0]  sum_reg;
    reg         clr_reg;
    reg  [CNT_WIDTH*`PEC_NUM_CNT-1:0] snap_reg;
    wire [CNT_WIDTH*`PEC_NUM_CNT-1:0] live;
    wire [`PEC_NUM_CNT-1:0]           ev_vec;
    wire        clear_all;
    wire        beat;
    reg  [7:0]  byte_val;

    // Outbound events versus inbound events kept apart by source
    assign ev_vec = {rx_fis_other_err_in,
                     rx_fis_crc_err_in,
                     sig_fis_sent_in,
                     phy_rdy_drop_in,
                     icrc_cmd_fail_in};

    assign beat      = page_valid_out && page_ready_in;
    // Clear applied when the last byte leaves, so the page reports pre-clear values
    assign clear_all = bist_activate_in ||
                       (beat && page_last_out && clr_reg);

    genvar g;
    generate
        for (g = 0; g < `PEC_NUM_CNT; g = g + 1) begin : g_cnt
            pec_sat_counter #(
                .WIDTH (CNT_WIDTH)
            ) u_cnt (
                .sys_clk_in (sys_clk_in),
                .sys_rst_in (sys_rst_in),
                .event_in   (ev_vec[g]),
                .clear_in   (clear_all),
                .count_out  (live[g*CNT_WIDTH +: CNT_WIDTH])
            );
        end
    endgenerate

    function [11:0] ev_code;
        input [2:0] n;
        begin
            case (n)
                3'd0:    ev_code = `PEC_EV_ICRC_CMD;
                3'd1:    ev_code = `PEC_EV_PHY_DROP;
                3'd2:    ev_code = `PEC_EV_SIG_SENT;
                3'd3:    ev_code = `PEC_EV_RX_CRC;
                3'd4:    ev_code = `PEC_EV_RX_OTHER;
                default: ev_code = `PEC_EV_END;
            endcase
        end
    endfunction

    // Identifier word: bit 15 reserved, size code, event code
    function [15:0] ident_word;
        input [2:0]  size;
        input [11:0] code;
        begin
            ident_word = {1'b0, size, code};
        end
    endfunction

    function [7:0] word_byte;
        input [15:0] word;
        input        lane;
        begin
            word_byte = lane ? word[15:8] : word[7:0];
        end
    endfunction

    // Page byte generator, values little-endian
    reg [9:0]  rel;
    reg [9:0]  ent_wide;
    reg [2:0]  ent;
    reg [9:0]  off;
    reg [15:0] ident;
    reg [CNT_WIDTH-1:0] val;
    always @* begin
        rel      = 10'd0;
        ent_wide = 10'd0;
        ent      = 3'd0;
        off      = 10'd0;
        ident    = 16'h0000;
        val      = {CNT_WIDTH{1'b0}};
        byte_val = 8'h00;
        if (idx_reg == 10'd0) begin
            byte_val = `PEC_HDR_BYTE0;
        end else if (idx_reg == `PEC_CSUM_BYTE) begin
            byte_val = 8'h00 - sum_reg;
        end else if (idx_reg >= `PEC_FIRST_ENTRY) begin
            rel = idx_reg - `PEC_FIRST_ENTRY;
            if (rel < LIST_BYTES) begin
                ent_wide = rel / ENTRY_BYTES;
                ent      = ent_wide[2:0];
                off      = rel - ent_wide * ENTRY_BYTES;
                ident    = ident_word(SIZE_CODE, ev_code(ent));
                val      = snap_reg[ent*CNT_WIDTH +: CNT_WIDTH];
                if (off < 10'd2) begin
                    byte_val = word_byte(ident, off[0]);
                end else begin
                    byte_val = val[(off-10'd2)*8 +: 8];
                end
            end else if (rel < LIST_BYTES + 10'd2) begin
                // End marker: size 0, event 000h, no value follows
                ident    = ident_word(3'h0, `PEC_EV_END);
                byte_val = word_byte(ident, rel[0]);
            end
            // Bytes past the end marker stay zero up to the checksum
        end
    end

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: if (read_start_in) state_next = ST_SEND;
            ST_SEND: if (beat && page_last_out) state_next = ST_DONE;
            ST_DONE: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            state_reg      <= ST_IDLE;
            idx_reg        <= 10'd0;
            sum_reg        <= 8'h00;
            clr_reg        <= 1'b0;
            snap_reg       <= {(CNT_WIDTH*`PEC_NUM_CNT){1'b0}};
            page_data_out  <= 8'h00;
            page_valid_out <= 1'b0;
            page_last_out  <= 1'b0;
        end else begin
            state_reg <= state_next;
            case (state_reg)
                ST_IDLE: begin
                    if (read_start_in) begin
                        // Snapshot keeps entries coherent while events continue
                        snap_reg <= live;
                        clr_reg  <= read_clear_in;
                        idx_reg  <= 10'd0;
                        sum_reg  <= 8'h00;
                    end
                end
                ST_SEND: begin
                    if (!page_valid_out || beat) begin
                        if (beat && page_last_out) begin
                            page_valid_out <= 1'b0;
                            page_last_out  <= 1'b0;
                        end else begin
                            page_data_out  <= byte_val;
                            page_valid_out <= 1'b1;
                            page_last_out  <= (idx_reg == `PEC_CSUM_BYTE);
                            sum_reg        <= sum_reg + byte_val;
                            idx_reg        <= idx_reg + 10'd1;
                        end
                    end
                end
                default: begin
                    page_valid_out <= 1'b0;
                    page_last_out  <= 1'b0;
                end
            endcase
        end
    end

    assign read_busy_out = (state_reg != ST_IDLE);
endmodule

// [rtl/pec_sat_counter.v]
`timescale 1ns/1ps
`include "pec_defines.vh"

module pec_sat_counter #(
    parameter WIDTH = 16
) (
    // Clock and reset
    input  wire             sys_clk_in,
    input  wire             sys_rst_in,
    // Control
    input  wire             event_in,
    input  wire             clear_in,
    // Value
    output wire [WIDTH-1:0] count_out
);
    reg [WIDTH-1:0] count_reg;
    reg [WIDTH-1:0] count_next;

    always @* begin
        count_next = count_reg;
        if (clear_in) begin
            // Clear beats a coincident event; the event belongs to the new epoch
            count_next = event_in ? {{(WIDTH-1){1'b0}}, 1'b1} : {WIDTH{1'b0}};
        end else if (event_in && (count_reg != {WIDTH{1'b1}})) begin
            count_next = count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    // Power-up reset and clear_in clear; link resets do not reach here
    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            count_reg <= {WIDTH{1'b0}};
        end else begin
            count_reg <= count_next;
        end
    end

    assign count_out = count_reg;
endmodule

// [sim/pec_event_log_assertions.sv]
`timescale 1ns/1ps
module pec_event_log_assertions #(
    parameter CNT_WIDTH = 16
) (
    // Clock and reset
    input wire       sys_clk_in,
    input wire       sys_rst_in,
    // Read and stream
    input wire       read_start_in,
    input wire       read_busy_out,
    input wire [7:0] page_data_out,
    input wire       page_valid_out,
    input wire       page_last_out,
    input wire       page_ready_in
);
    localparam END_BYTE = 4 + 5 * (2 + CNT_WIDTH / 8);
    reg  [9:0] beat_reg;
    reg  [7:0] sum_reg;
    wire       take = page_valid_out && page_ready_in;
    // Tallies restart whenever no read is in flight
    always @(posedge sys_clk_in) begin
        beat_reg <= read_busy_out ? beat_reg + {9'h000, take} : 10'h000;
        sum_reg  <= read_busy_out ? sum_reg + (take ? page_data_out : 8'h00) : 8'h00;
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence s_answer; read_busy_out ##1 page_valid_out; endsequence
    sequence s_close; !page_valid_out ##1 !read_busy_out; endsequence
    start_answer_a: assert property (read_start_in && !read_busy_out |=> s_answer)
        else $error("no answer to read");
    byte_hold_a: assert property (page_valid_out && !page_ready_in |=> page_valid_out && $stable(page_data_out))
        else $error("byte not held");
    first_byte_a: assert property ($rose(page_valid_out) |-> page_data_out == 8'h01)
        else $error("bad first byte");
    page_close_a: assert property (take && page_last_out |=> s_close)
        else $error("bad page end");
    idle_quiet_a: assert property (!read_busy_out |-> !page_valid_out)
        else $error("valid while idle");
    page_length_a: assert property (take && page_last_out |-> beat_reg == 10'h1ff)
        else $error("page length wrong");
    page_sum_a: assert property (take && page_last_out |-> sum_reg + page_data_out == 8'h00)
        else $error("page sum not zero");
    end_pad_a: assert property (page_valid_out && beat_reg >= END_BYTE && beat_reg < 511 |-> page_data_out == 8'h00)
        else $error("end marker or pad not zero");
endmodule
bind pec_event_log pec_event_log_assertions #(.CNT_WIDTH(CNT_WIDTH)) i_chk (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .read_start_in(read_start_in),
    .read_busy_out(read_busy_out), .page_data_out(page_data_out), .page_valid_out(page_valid_out),
    .page_last_out(page_last_out), .page_ready_in(page_ready_in));

// [sim/pec_event_log_test.sv]
`timescale 1ns/1ps
module pec_event_log_test;
    reg         sys_clk_in = 1'b0;
    reg         sys_rst_in = 1'b1;
    reg  [4:0]  ev = 5'h00;
    reg         bist = 1'b0;
    reg         start = 1'b0;
    reg         clr = 1'b0;
    reg         slow = 1'b0;
    wire        busy, valid, last, ready;
    wire [7:0]  data;
    integer     fail_count = 0;
    integer     compares = 0;
    reg  [15:0] cnt [0:4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    reg  [7:0]  ids [0:4] = '{8'h01, 8'h09, 8'h0a, 8'h0b, 8'h0d};
    always #2.5 sys_clk_in = !sys_clk_in;
    pec_event_log i_dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .icrc_cmd_fail_in(ev[0]),
        .phy_rdy_drop_in(ev[1]), .sig_fis_sent_in(ev[2]), .rx_fis_crc_err_in(ev[3]),
        .rx_fis_other_err_in(ev[4]), .bist_activate_in(bist), .read_start_in(start), .read_clear_in(clr),
        .read_busy_out(busy), .page_data_out(data), .page_valid_out(valid), .page_last_out(last),
        .page_ready_in(ready));
    pec_host_model i_host (.sys_clk_in(sys_clk_in), .valid_in(valid), .last_in(last), .data_in(data),
        .slow_in(slow), .ready_out(ready));
    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task close_out;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task tick(input integer k);
        repeat (k) @(posedge sys_clk_in);
        #1;
    endtask
    task pulse(input integer k, input integer times);
        repeat (times) begin
            ev[k] = 1'b1;
            tick(1);
            ev[k] = 1'b0;
            tick(1);
        end
        cnt[k] = cnt[k] + times;
    endtask
    // Reads one page and compares every byte with the expected image
    // A non-zero poke fires a refused clearing start and one event 3 mid-page
    task rd(input logic c, input integer poke);
        integer     i, j, p;
        logic [7:0] s, b;
        p = i_host.pages;
        start = 1'b1;
        clr = c;
        tick(1);
        start = 1'b0;
        clr = 1'b0;
        i = 0;
        while (busy !== 1'b0 && i < 3000) begin
            tick(1);
            i = i + 1;
            start = (i == poke);
            clr = (i == poke);
            ev[3] = (i == poke);
        end
        if (i == 3000) begin
            fail_count = fail_count + 1;
            close_out;
        end
        s = 8'h00;
        for (i = 0; i < 511; i = i + 1) begin
            j = i / 4 - 1;
            b = (i == 0) ? 8'h01 : 8'h00;
            if (i >= 4 && i < 24)
                b = (i % 4 == 0) ? ids[j] : (i % 4 == 1) ? 8'h10 : (i % 4 == 2) ? cnt[j][7:0] : cnt[j][15:8];
            chk("page byte", i_host.pg[i], b);
            s = s + b;
        end
        s = -s;
        chk("checksum", i_host.pg[511], s);
        chk("pages", 16'(i_host.pages - p), 16'h0001);
        // The snapshot hides the mid-page event until the next read
        if (poke > 0)
            cnt[3] = cnt[3] + 16'h0001;
        if (c)
            for (i = 0; i < 5; i = i + 1) cnt[i] = 16'h0000;
    endtask
    task t_counts;
        integer k;
        for (k = 0; k < 5; k = k + 1) pulse(k, k + 1);
        rd(1'b0, 10);
        rd(1'b0, 0);
    endtask
    task t_clear;
        slow = 1'b1;
        rd(1'b1, 0);
        slow = 1'b0;
        rd(1'b0, 0);
    endtask
    task t_bist;
        pulse(1, 3);
        pulse(4, 2);
        // Event in the clearing cycle starts the new count at one
        bist = 1'b1;
        ev[2] = 1'b1;
        tick(1);
        bist = 1'b0;
        ev[2] = 1'b0;
        cnt[1] = 16'h0000;
        cnt[2] = 16'h0001;
        cnt[4] = 16'h0000;
        rd(1'b0, 0);
    endtask
    task t_sat;
        ev[0] = 1'b1;
        tick(65540);
        ev[0] = 1'b0;
        cnt[0] = 16'hffff;
        rd(1'b1, 0);
    endtask
    initial begin
        tick(6);
        sys_rst_in = 1'b0;
        t_counts;
        t_clear;
        t_bist;
        t_sat;
        close_out;
    end
endmodule

// [sim/pec_host_model.sv]
`timescale 1ns/1ps
module pec_host_model (
    // Byte sink
    input  wire       sys_clk_in,
    input  wire       valid_in,
    input  wire       last_in,
    input  wire [7:0] data_in,
    input  wire       slow_in,
    output reg        ready_out
);
    reg [7:0] pg [0:511];
    integer   n = 0;
    integer   pages = 0;
    initial ready_out = 1'b1;
    // Slow mode refuses every other beat
    always @(posedge sys_clk_in) begin
        ready_out <= #1 !slow_in || !ready_out;
        if (valid_in && ready_out) begin
            pg[n] <= data_in;
            n <= last_in ? 0 : n + 1;
            if (last_in)
                pages <= pages + 1;
        end
    end
endmodule
